// file: hdl/ufc_pkg.sv
// ufc_pkg: register map, bit positions and read values of the
// interrupt-clear and fifo-clear block.
// assumes a 16-bit cpu address space and 8-bit data.
package ufc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [15:0] ADDR_BULK_IN_INT_CLR = 16'hff4c;
    localparam logic [15:0] ADDR_BULK_OUT_INT_CLR = 16'hff4d;
    localparam logic [15:0] ADDR_IF_REQ_INT_CLR = 16'hff4e;
    localparam logic [15:0] ADDR_FIFO_CLR_FIRST = 16'hff79;
    // -----------------------------------------------------------------
    // read values and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] INT_CLR_READ = 8'hff;
    localparam logic [7:0] FIFO_CLR_READ = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // -----------------------------------------------------------------
    // bit positions in the clear registers
    // -----------------------------------------------------------------
    localparam int BIT_BULK_IN_TOKEN = 5;
    localparam int BIT_BULK_IN_DATA = 4;
    localparam int BIT_BULK_OUT_FULL = 3;
    localparam int BIT_BULK_OUT_NULL = 2;
    localparam int BIT_BULK_OUT_NAK = 1;
    localparam int BIT_BULK_OUT_DATA = 0;
    localparam int BIT_SET_INTERFACE = 5;
    localparam int BIT_BULK_IN_ENGINE_CLR = 5;
    localparam int BIT_BULK_IN_CPU_CLR = 4;
    localparam int BIT_CTRL_TX_CLR = 1;
    localparam int BIT_CTRL_RX_CLR = 0;
    // -----------------------------------------------------------------
    // internal status vector layout
    // -----------------------------------------------------------------
    localparam int NUM_SRC = 7;
    localparam int SRC_BO_DATA = 0;
    localparam int SRC_BO_NAK = 1;
    localparam int SRC_BO_NULL = 2;
    localparam int SRC_BO_FULL = 3;
    localparam int SRC_BI_DATA = 4;
    localparam int SRC_BI_TOKEN = 5;
    localparam int SRC_SET_IF = 6;
    localparam logic [6:0] STATUS_RESET = 7'h00;
endpackage : ufc_pkg

// file: hdl/ufc_int_fifo_clear.sv
// ufc_int_fifo_clear: interrupt-source clear registers and first fifo-clear
// register of a usb function controller, with the status and ready flags
// they act on.
// assumes cpu strobes and all event inputs are on clk, one-cycle pulses.
//
// Contract
// (R01) interrupt-clear registers are write-only bytes reading back ffh
// (R02) writing zero clears the matching status bit; one does nothing
// (R03) clear bits restore to one by themselves; register rests at ffh
// (R04) firmware clear works even for sources hardware clears later
// (R05) clear bits of unsupported endpoints have no effect
// (R06) bulk-in clear: bit 5 token, bit 4 data; others fixed one
// (R07) bulk-out clear: bits 3..0 full, null, nak, data
// (R08) interface-request clear: bit 5 set-interface interrupt
// (R09) fifo-clear register is write-only byte reading back zero
// (R10) writing one clears the fifo, bit self-clears; zero does nothing
// (R11) bit 5 empties only engine side of bulk-in fifo and counter
// (R12) engine-side clear ignored while ep1 in token busy with ready set
// (R13) engine-side clear also drops bulk-in ready flag
// (R14) firmware empties cpu-side bulk-in fifo before engine-side clear
// (R15) bit 1 clears control transmit buffer and its counter
// (R16) transmit clear ignored while ep0 in token busy with ready set
// (R17) transmit clear also drops control transmit ready flag
// (R18) bit 0 clears control receive buffer and its counter
// (R19) receive clear drops hardware-set receive ready; firmware-set stays
// (R20) bit 4 empties only cpu side of bulk-in fifo and counter
// (R21) firmware clear removes source from request in the write cycle
`timescale 1ns/1ps
module ufc_int_fifo_clear (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ufc_pkg::ADDR_W-1:0] cpuAddr,
    input wire logic [ufc_pkg::DATA_W-1:0] cpuWrData,
    input wire logic cpuWr,
    input wire logic cpuRd,
    output logic [ufc_pkg::DATA_W-1:0] cpuRdData,
    input wire logic inEpSupported,
    input wire logic outEpSupported,
    input wire logic [1:0] bulkInEvent,
    input wire logic [3:0] bulkOutEvent,
    input wire logic setIfEvent,
    input wire logic [1:0] bulkInHwClear,
    input wire logic [3:0] bulkOutHwClear,
    input wire logic setIfHwClear,
    output logic [1:0] bulkInStatus,
    output logic [3:0] bulkOutStatus,
    output logic setIfStatus,
    output logic intRequest,
    input wire logic ep1InBusy,
    input wire logic ep0InBusy,
    input wire logic bulkInReadySet,
    input wire logic bulkInReadyHwClear,
    input wire logic ctrlTxReadySet,
    input wire logic ctrlTxReadyHwClear,
    input wire logic ctrlRxReadyHwSet,
    input wire logic ctrlRxReadyFwSet,
    input wire logic ctrlRxReadyHwClear,
    output logic bulkInReadyFlag,
    output logic ctrlTxReadyFlag,
    output logic ctrlRxReadyFlag,
    output logic bulkInEngineSideClear,
    output logic bulkInCpuSideClear,
    output logic ctrlTxBufferClear,
    output logic ctrlRxBufferClear
);
    import ufc_pkg::*;

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    logic hitBulkIn;
    logic hitBulkOut;
    logic hitIfReq;
    logic hitFifo;
    logic [NUM_SRC-1:0] srcEvent;
    logic [NUM_SRC-1:0] srcHwClr;
    logic [NUM_SRC-1:0] fwClr;
    logic [NUM_SRC-1:0] status_reg;
    logic [NUM_SRC-1:0] status_next;
    logic engClr;
    logic cpuClr;
    logic txClr;
    logic rxClr;
    logic rxFwSet_reg;

    assign hitBulkIn = cpuAddr == ADDR_BULK_IN_INT_CLR;
    assign hitBulkOut = cpuAddr == ADDR_BULK_OUT_INT_CLR;
    assign hitIfReq = cpuAddr == ADDR_IF_REQ_INT_CLR;
    assign hitFifo = cpuAddr == ADDR_FIFO_CLR_FIRST;

    // -----------------------------------------------------------------
    // read port
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuRdData <= UNMAPPED_READ;
        end else if (cpuRd) begin
            if (hitBulkIn || hitBulkOut || hitIfReq) begin
                cpuRdData <= INT_CLR_READ; // R01
            end else if (hitFifo) begin
                cpuRdData <= FIFO_CLR_READ; // R09
            end else begin
                cpuRdData <= UNMAPPED_READ;
            end
        end
    end

    // -----------------------------------------------------------------
    // interrupt-source clear decode
    // -----------------------------------------------------------------
    // clear strobes exist only in the write cycle: the register itself
    // holds nothing and always reads as all ones
    always_comb begin
        fwClr = '0;
        // R06
        fwClr[SRC_BI_TOKEN] = cpuWr && hitBulkIn && inEpSupported &&
            !cpuWrData[BIT_BULK_IN_TOKEN]; // R02 R03 R05
        fwClr[SRC_BI_DATA] = cpuWr && hitBulkIn && inEpSupported &&
            !cpuWrData[BIT_BULK_IN_DATA]; // R02 R05
        // R07
        fwClr[SRC_BO_FULL] = cpuWr && hitBulkOut && outEpSupported &&
            !cpuWrData[BIT_BULK_OUT_FULL]; // R05
        fwClr[SRC_BO_NULL] = cpuWr && hitBulkOut && outEpSupported &&
            !cpuWrData[BIT_BULK_OUT_NULL]; // R05
        fwClr[SRC_BO_NAK] = cpuWr && hitBulkOut && outEpSupported &&
            !cpuWrData[BIT_BULK_OUT_NAK]; // R05
        fwClr[SRC_BO_DATA] = cpuWr && hitBulkOut && outEpSupported &&
            !cpuWrData[BIT_BULK_OUT_DATA]; // R05
        // R08
        fwClr[SRC_SET_IF] = cpuWr && hitIfReq &&
            (inEpSupported || outEpSupported) &&
            !cpuWrData[BIT_SET_INTERFACE]; // R05
    end

    assign srcEvent = {setIfEvent, bulkInEvent, bulkOutEvent};
    assign srcHwClr = {setIfHwClear, bulkInHwClear, bulkOutHwClear};

    // -----------------------------------------------------------------
    // status bits: new event wins over any clear
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            assign status_next[gi] = srcEvent[gi] ||
                (status_reg[gi] && !fwClr[gi] && !srcHwClr[gi]); // R02 R04
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign bulkInStatus = status_reg[SRC_BI_TOKEN:SRC_BI_DATA];
    assign bulkOutStatus = status_reg[SRC_BO_FULL:SRC_BO_DATA];
    assign setIfStatus = status_reg[SRC_SET_IF];

    // request follows the status next value so a clear lands with it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intRequest <= 1'b0;
        end else begin
            intRequest <= |status_next; // R21
        end
    end

    // -----------------------------------------------------------------
    // fifo-clear decode
    // -----------------------------------------------------------------
    assign engClr = cpuWr && hitFifo && inEpSupported &&
        cpuWrData[BIT_BULK_IN_ENGINE_CLR] &&
        !(ep1InBusy && bulkInReadyFlag); // R10 R11 R12 R05
    assign cpuClr = cpuWr && hitFifo && inEpSupported &&
        cpuWrData[BIT_BULK_IN_CPU_CLR]; // R20 R05
    assign txClr = cpuWr && hitFifo && cpuWrData[BIT_CTRL_TX_CLR] &&
        !(ep0InBusy && ctrlTxReadyFlag); // R15 R16
    assign rxClr = cpuWr && hitFifo && cpuWrData[BIT_CTRL_RX_CLR]; // R18

    // one-cycle pulses; the bits self-clear on the next edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bulkInEngineSideClear <= 1'b0;
            bulkInCpuSideClear <= 1'b0;
            ctrlTxBufferClear <= 1'b0;
            ctrlRxBufferClear <= 1'b0;
        end else begin
            bulkInEngineSideClear <= engClr; // R10 R11
            bulkInCpuSideClear <= cpuClr; // R10 R20
            ctrlTxBufferClear <= txClr; // R10 R15
            ctrlRxBufferClear <= rxClr; // R10 R18
        end
    end

    // -----------------------------------------------------------------
    // ready flags
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bulkInReadyFlag <= 1'b0;
        end else if (bulkInReadySet) begin
            bulkInReadyFlag <= 1'b1;
        end else if (engClr || bulkInReadyHwClear) begin
            bulkInReadyFlag <= 1'b0; // R13
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlTxReadyFlag <= 1'b0;
        end else if (ctrlTxReadySet) begin
            ctrlTxReadyFlag <= 1'b1;
        end else if (txClr || ctrlTxReadyHwClear) begin
            ctrlTxReadyFlag <= 1'b0; // R17
        end
    end

    // remembers who set the receive flag; a firmware set survives the receive clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlRxReadyFlag <= 1'b0;
            rxFwSet_reg <= 1'b0;
        end else if (ctrlRxReadyFwSet) begin
            ctrlRxReadyFlag <= 1'b1;
            rxFwSet_reg <= 1'b1;
        end else if (ctrlRxReadyHwSet) begin
            ctrlRxReadyFlag <= 1'b1;
            rxFwSet_reg <= 1'b0;
        end else if (ctrlRxReadyHwClear ||
                     (rxClr && !rxFwSet_reg)) begin
            ctrlRxReadyFlag <= 1'b0; // R19
            rxFwSet_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ic_read_ones: assert property ( // R01
        cpuRd && (hitBulkIn || hitBulkOut || hitIfReq)
        |=> cpuRdData == 8'hff)
        else $error("interrupt-clear read not ffh");
    a_fifo_read_zero: assert property ( // R09
        cpuRd && hitFifo |=> cpuRdData == 8'h00)
        else $error("fifo-clear read not zero");
    a_token_clear: assert property ( // R06
        cpuWr && hitBulkIn && inEpSupported && !cpuWrData[5] &&
        !bulkInEvent[1] |=> !bulkInStatus[1])
        else $error("bulk-in token source not cleared");
    a_one_no_effect: assert property ( // R02
        cpuWr && hitBulkOut && cpuWrData[3] && bulkOutStatus[3] &&
        !bulkOutHwClear[3] |=> bulkOutStatus[3])
        else $error("writing one cleared a source");
    a_unsupported_ignored: assert property ( // R05
        !outEpSupported && bulkOutStatus[0] && !bulkOutHwClear[0]
        |=> bulkOutStatus[0])
        else $error("unsupported endpoint clear took effect");
    a_setif_clear: assert property ( // R08
        cpuWr && hitIfReq && !cpuWrData[5] && inEpSupported &&
        !setIfEvent |=> !setIfStatus)
        else $error("set-interface source not cleared");
    a_event_wins: assert property ( // R21
        bulkOutEvent[2] |=> bulkOutStatus[2] && intRequest)
        else $error("event lost against clear");
    a_req_drops: assert property ( // R21
        intRequest && fwClr == status_reg && srcEvent == '0
        |=> !intRequest)
        else $error("request not removed with clear");
    a_pulse_once: assert property ( // R10
        cpuWr && hitFifo && cpuWrData[0] |=> ctrlRxBufferClear
        ##1 (!ctrlRxBufferClear || $past(rxClr)))
        else $error("fifo-clear pulse not one cycle");
    a_eng_busy_ignored: assert property ( // R12
        cpuWr && hitFifo && ep1InBusy && bulkInReadyFlag
        |=> !bulkInEngineSideClear)
        else $error("engine-side clear taken while busy");
    a_ready_drop: assert property ( // R13
        bulkInEngineSideClear && !$past(bulkInReadySet) |-> !bulkInReadyFlag)
        else $error("bulk-in ready flag kept after clear");
    a_tx_busy: assert property ( // R16
        cpuWr && hitFifo && ep0InBusy && ctrlTxReadyFlag &&
        !ctrlTxReadyHwClear
        |=> !ctrlTxBufferClear && ctrlTxReadyFlag)
        else $error("transmit clear taken while busy");
    a_rx_fw_kept: assert property ( // R19
        ctrlRxReadyFlag && rxFwSet_reg && !ctrlRxReadyHwClear &&
        !ctrlRxReadyHwSet |=> ctrlRxReadyFlag)
        else $error("firmware-set receive flag dropped");

    a_eng_clear_taken: assert property ( // R11
        cpuWr && hitFifo && inEpSupported &&
        cpuWrData[BIT_BULK_IN_ENGINE_CLR] && !(ep1InBusy && bulkInReadyFlag)
        |=> bulkInEngineSideClear)
        else $error("engine-side clear not issued");
    a_cpu_clear_taken: assert property ( // R20
        cpuWr && hitFifo && inEpSupported && cpuWrData[BIT_BULK_IN_CPU_CLR]
        |=> bulkInCpuSideClear)
        else $error("cpu-side clear not issued");
    a_fifo_gated: assert property ( // R05
        cpuWr && !inEpSupported |=> !bulkInEngineSideClear &&
        !bulkInCpuSideClear)
        else $error("bulk-in fifo clear for unsupported endpoint");
    a_tx_clear_taken: assert property ( // R15
        cpuWr && hitFifo && cpuWrData[BIT_CTRL_TX_CLR] &&
        !(ep0InBusy && ctrlTxReadyFlag) |=> ctrlTxBufferClear)
        else $error("transmit buffer clear not issued");
    a_tx_ready_drop: assert property ( // R17
        ctrlTxBufferClear && !$past(ctrlTxReadySet) |-> !ctrlTxReadyFlag)
        else $error("transmit ready flag kept after clear");
    a_rx_clear_taken: assert property ( // R18
        cpuWr && hitFifo && cpuWrData[BIT_CTRL_RX_CLR] |=> ctrlRxBufferClear)
        else $error("receive buffer clear not issued");
    a_zero_ignored: assert property ( // R10
        cpuWr && hitFifo && !cpuWrData[BIT_CTRL_RX_CLR]
        |=> !ctrlRxBufferClear)
        else $error("fifo clear issued for a zero bit");
    a_rx_hw_drop: assert property ( // R19
        cpuWr && hitFifo && cpuWrData[BIT_CTRL_RX_CLR] && !rxFwSet_reg &&
        !ctrlRxReadyFwSet && !ctrlRxReadyHwSet |=> !ctrlRxReadyFlag)
        else $error("hardware-set receive flag kept after clear");
    a_fw_clear_early: assert property ( // R04
        cpuWr && hitBulkOut && outEpSupported &&
        !cpuWrData[BIT_BULK_OUT_NULL] && !bulkOutEvent[2]
        |=> !bulkOutStatus[2])
        else $error("firmware clear not taken ahead of hardware");
    a_event_sets: assert property ( // R21
        bulkInEvent[0] |=> bulkInStatus[0] && intRequest)
        else $error("data event did not raise status and request");
    a_req_is_or: assert property ( // R21
        intRequest == |{setIfStatus, bulkInStatus, bulkOutStatus})
        else $error("request differs from combined status");

    // -----------------------------------------------------------------
    // cover properties
    // -----------------------------------------------------------------
    c_tx_busy: cover property (
        cpuWr && hitFifo && ep0InBusy && ctrlTxReadyFlag);
    c_token_clear: cover property (
        bulkInStatus[1] ##1 fwClr[SRC_BI_TOKEN] ##1 !bulkInStatus[1]);
    c_eng_clear: cover property (bulkInReadyFlag ##1 bulkInEngineSideClear);
    c_set_vs_clear: cover property (fwClr[SRC_BO_NAK] && bulkOutEvent[1]);
    c_rx_fw_kept: cover property (rxClr && rxFwSet_reg && ctrlRxReadyFlag);
endmodule : ufc_int_fifo_clear

// file: testbench/ufc_host_model.sv
// ufc_host_model: far side of the block, the usb host as seen through
// the serial interface engine; drives event, auto-clear, ready and busy.
// assumes the testbench calls fire and busy; all changes on clk rise.
`timescale 1ns/1ps
module ufc_host_model (
    input wire logic clk,
    output logic [1:0] bulkInEvent,
    output logic [3:0] bulkOutEvent,
    output logic setIfEvent,
    output logic [1:0] bulkInHwClear,
    output logic [3:0] bulkOutHwClear,
    output logic setIfHwClear,
    output logic bulkInReadySet,
    output logic bulkInReadyHwClear,
    output logic ctrlTxReadySet,
    output logic ctrlTxReadyHwClear,
    output logic ctrlRxReadyHwSet,
    output logic ctrlRxReadyFwSet,
    output logic ctrlRxReadyHwClear,
    output logic ep1InBusy,
    output logic ep0InBusy
);
    // -----------------------------------------------------------------
    // one-cycle pulses, packed for the caller
    // -----------------------------------------------------------------
    logic [20:0] pulseVec = '0;
    assign {ctrlRxReadyHwClear, ctrlRxReadyFwSet, ctrlRxReadyHwSet,
        ctrlTxReadyHwClear, ctrlTxReadySet, bulkInReadyHwClear,
        bulkInReadySet, setIfHwClear, bulkOutHwClear, bulkInHwClear,
        setIfEvent, bulkOutEvent, bulkInEvent} = pulseVec;
    initial begin
        ep1InBusy = 1'b0;
        ep0InBusy = 1'b0;
    end
    task fire(input logic [20:0] m);
        @(posedge clk);
        pulseVec <= m;
        @(posedge clk);
        pulseVec <= '0;
    endtask : fire
    // in tokens in service, levels held until changed
    task busy(input logic [1:0] b);
        @(posedge clk);
        {ep1InBusy, ep0InBusy} <= b;
    endtask : busy
endmodule : ufc_host_model

// file: testbench/test_usb_function_int_fifo_clear.sv
// test_usb_function_int_fifo_clear: register-level bench of the clear block.
// assumes ufc_pkg, ufc_int_fifo_clear and ufc_host_model are compiled.
`timescale 1ns/1ps
module test_usb_function_int_fifo_clear;
    import ufc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] cpuAddr = '0;
    logic [7:0] cpuWrData = '0;
    logic cpuWr = 1'b0;
    logic cpuRd = 1'b0;
    logic inEpSupported = 1'b1;
    logic outEpSupported = 1'b1;
    logic [7:0] cpuRdData;
    logic [1:0] bulkInEvent, bulkInHwClear, bulkInStatus;
    logic [3:0] bulkOutEvent, bulkOutHwClear, bulkOutStatus;
    logic setIfEvent, setIfHwClear, setIfStatus, intRequest;
    logic ep1InBusy, ep0InBusy, bulkInReadySet, bulkInReadyHwClear;
    logic ctrlTxReadySet, ctrlTxReadyHwClear, ctrlRxReadyHwSet;
    logic ctrlRxReadyFwSet, ctrlRxReadyHwClear;
    logic bulkInReadyFlag, ctrlTxReadyFlag, ctrlRxReadyFlag;
    logic bulkInEngineSideClear, bulkInCpuSideClear;
    logic ctrlTxBufferClear, ctrlRxBufferClear;
    logic [7:0] statView;
    logic [7:0] fifoView;
    logic [7:0] expStat;
    int mismatches = 0;
    int n_checks = 0;
    logic [15:0] clrAddr [7] = '{16'hff4c, 16'hff4c, 16'hff4d, 16'hff4d,
        16'hff4d, 16'hff4d, 16'hff4e};
    logic [7:0] clrData [7] = '{8'hdf, 8'hef, 8'hf7, 8'hfb, 8'hfd, 8'hfe,
        8'hdf};
    logic [7:0] clrMask [7] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
        8'h40};
    assign statView = {1'b0, setIfStatus, bulkInStatus, bulkOutStatus};
    assign fifoView = {1'b0, bulkInEngineSideClear, bulkInCpuSideClear,
        ctrlTxBufferClear, ctrlRxBufferClear, bulkInReadyFlag,
        ctrlTxReadyFlag, ctrlRxReadyFlag};
    // -----------------------------------------------------------------
    // instances
    // -----------------------------------------------------------------
    ufc_int_fifo_clear ufc_int_fifo_clear_inst (.clk(clk), .rst_b(rst_b),
        .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuWr(cpuWr),
        .cpuRd(cpuRd), .cpuRdData(cpuRdData),
        .inEpSupported(inEpSupported), .outEpSupported(outEpSupported),
        .bulkInEvent(bulkInEvent), .bulkOutEvent(bulkOutEvent),
        .setIfEvent(setIfEvent), .bulkInHwClear(bulkInHwClear),
        .bulkOutHwClear(bulkOutHwClear), .setIfHwClear(setIfHwClear),
        .bulkInStatus(bulkInStatus), .bulkOutStatus(bulkOutStatus),
        .setIfStatus(setIfStatus), .intRequest(intRequest),
        .ep1InBusy(ep1InBusy), .ep0InBusy(ep0InBusy),
        .bulkInReadySet(bulkInReadySet),
        .bulkInReadyHwClear(bulkInReadyHwClear),
        .ctrlTxReadySet(ctrlTxReadySet),
        .ctrlTxReadyHwClear(ctrlTxReadyHwClear),
        .ctrlRxReadyHwSet(ctrlRxReadyHwSet),
        .ctrlRxReadyFwSet(ctrlRxReadyFwSet),
        .ctrlRxReadyHwClear(ctrlRxReadyHwClear),
        .bulkInReadyFlag(bulkInReadyFlag), .ctrlTxReadyFlag(ctrlTxReadyFlag),
        .ctrlRxReadyFlag(ctrlRxReadyFlag),
        .bulkInEngineSideClear(bulkInEngineSideClear),
        .bulkInCpuSideClear(bulkInCpuSideClear),
        .ctrlTxBufferClear(ctrlTxBufferClear),
        .ctrlRxBufferClear(ctrlRxBufferClear));
    ufc_host_model ufc_host_model_inst (.clk(clk),
        .bulkInEvent(bulkInEvent), .bulkOutEvent(bulkOutEvent),
        .setIfEvent(setIfEvent), .bulkInHwClear(bulkInHwClear),
        .bulkOutHwClear(bulkOutHwClear), .setIfHwClear(setIfHwClear),
        .bulkInReadySet(bulkInReadySet),
        .bulkInReadyHwClear(bulkInReadyHwClear),
        .ctrlTxReadySet(ctrlTxReadySet),
        .ctrlTxReadyHwClear(ctrlTxReadyHwClear),
        .ctrlRxReadyHwSet(ctrlRxReadyHwSet),
        .ctrlRxReadyFwSet(ctrlRxReadyFwSet),
        .ctrlRxReadyHwClear(ctrlRxReadyHwClear),
        .ep1InBusy(ep1InBusy), .ep0InBusy(ep0InBusy));
    // -----------------------------------------------------------------
    // access tasks and checking
    // -----------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpuWr <= 1'b1;
        cpuAddr <= a;
        cpuWrData <= d;
        @(posedge clk);
        cpuWr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        cpuRd <= 1'b1;
        cpuAddr <= a;
        @(posedge clk);
        cpuRd <= 1'b0;
        #1;
        check(cpuRdData, exp);
    endtask : rd
    task ev(input logic [20:0] m);
        ufc_host_model_inst.fire(m);
        #1;
    endtask : ev
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    // -----------------------------------------------------------------
    // clock, watchdog and sequence
    // -----------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(16'hff4c, 8'hff);
        rd(16'hff4d, 8'hff);
        rd(16'hff4e, 8'hff);
        rd(16'hff79, 8'h00);
        rd(16'hff50, UNMAPPED_READ);
        ev(21'h00007f);
        wr(16'hff4c, 8'hff);
        wr(16'hff4d, 8'hff);
        wr(16'hff4e, 8'hff);
        check(statView, 8'h7f);
        expStat = 8'h7f;
        for (int i = 0; i < 7; i++) begin
            wr(clrAddr[i], clrData[i]);
            expStat = expStat & ~clrMask[i];
            check(statView, expStat);
            check({7'h00, intRequest}, {7'h00, |expStat});
            rd(clrAddr[i], 8'hff);
        end
        // support gating per endpoint
        ev(21'h00007f);
        @(posedge clk);
        inEpSupported <= 1'b0;
        outEpSupported <= 1'b0;
        wr(16'hff4c, 8'h00);
        wr(16'hff4e, 8'h00);
        check(statView, 8'h7f);
        @(posedge clk);
        inEpSupported <= 1'b1;
        wr(16'hff4d, 8'h00);
        check(statView, 8'h7f);
        wr(16'hff4c, 8'h00);
        check(statView, 8'h4f);
        wr(16'hff4e, 8'h00);
        check(statView, 8'h0f);
        @(posedge clk);
        outEpSupported <= 1'b1;
        wr(16'hff4d, 8'h00);
        check({7'h00, intRequest}, 8'h00);
        ev(21'h00007f);
        wr(16'hff4c, 8'hcf);
        ev(21'h000180);
        check(statView, 8'h4f);
        // event and clear of the same sources in one cycle
        fork
            ev(21'h000018);
            wr(16'hff4d, 8'hf9);
        join
        check(statView, 8'h4f);
        // fifo clears against the ready flags
        ev(21'h054000);
        wr(16'hff79, 8'h00);
        check(fifoView, 8'h07);
        wr(16'hff79, 8'h10);
        check(fifoView, 8'h27);
        @(posedge clk);
        #1;
        check(fifoView, 8'h07);
        ufc_host_model_inst.busy(2'b11);
        wr(16'hff79, 8'h22);
        check(fifoView, 8'h07);
        ufc_host_model_inst.busy(2'b00);
        wr(16'hff79, 8'h22);
        check(fifoView, 8'h51);
        wr(16'hff79, 8'h01);
        check(fifoView, 8'h08);
        ev(21'h080000);
        wr(16'hff79, 8'h01);
        check(fifoView, 8'h09);
        @(posedge clk);
        inEpSupported <= 1'b0;
        ev(21'h004000);
        wr(16'hff79, 8'h30);
        check(fifoView, 8'h05);
        rd(16'hff79, 8'h00);
        close_out();
    end
endmodule : test_usb_function_int_fifo_clear
